// >>> port_d_upper_pin_function_select.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module port_d_upper_pin_function_select
   import pinsel_pkg::*;
#(
   parameter int unsigned PINS = NPINS
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   // boot strap: rom disabled, 16-bit expansion
   input  wire logic              boot_ext16_i,
   // register port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   // pads, index 0 is pin 19
   input  wire logic [PINS-1:0]   pad_i,
   output logic      [PINS-1:0]   pad_o,
   output logic      [PINS-1:0]   pad_oe_o,
   // general port side
   input  wire logic [PINS-1:0]   port_o_i,
   input  wire logic [PINS-1:0]   port_oe_i,
   output logic      [PINS-1:0]   port_in_o,
   // bus controller data lines 19..27
   input  wire logic [PINS-1:0]   bus_o_i,
   input  wire logic [PINS-1:0]   bus_oe_i,
   output logic      [PINS-1:0]   bus_in_o,
   // dma controller
   input  wire logic              dma_ack_ch0_i,
   input  wire logic              dma_ack_ch1_i,
   output logic                   dma_req_ch0_o,
   output logic                   dma_req_ch1_o,
   // interrupt controller
   output logic      [4:0]        ext_interrupt_o,
   // debug trace unit
   input  wire logic              trace_sync_o_i,
   input  wire logic              trace_sync_oe_i,
   input  wire logic              trace_clock_o_i,
   input  wire logic              trace_clock_oe_i,
   input  wire logic              trace_data_bit3_o_i,
   input  wire logic              trace_data_bit3_oe_i,
   output logic                   trace_sync_o,
   output logic                   trace_clock_o,
   output logic                   trace_mode_in_o,
   output logic                   trace_reset_in_o,
   output logic                   trace_data_bit3_o
);

   if (PINS != NPINS) begin : g_pins_bad
      $error("PINS must equal the nine upper pins");
   end
   if (PIN19_LSB + 2 * NPINS > 2 * DATA_W) begin : g_map_bad
      $error("mode fields run past the two registers");
   end
   if (DATA_W != 16) begin : g_width_bad
      $error("select registers are sixteen bits wide");
   end

   // reset release
   logic       rst_s1_q;
   logic       rst_n_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // strap and pad synchronisers
   logic              strap_s1_q;
   logic              strap_q;
   logic [PINS-1:0]   pad_s1_q;
   logic [PINS-1:0]   pad_q;
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         strap_s1_q <= 1'b0;
         strap_q    <= 1'b0;
         pad_s1_q   <= '0;
         pad_q      <= '0;
      end else begin
         strap_s1_q <= boot_ext16_i;
         strap_q    <= strap_s1_q;
         pad_s1_q   <= pad_i;
         pad_q      <= pad_s1_q;
      end
   end

   // strap applied once, on the first edge its synchroniser holds the pin
   logic [2:0] boot_wait_q;
   logic       boot_load;
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         boot_wait_q <= '0;
      end else begin
         boot_wait_q <= {boot_wait_q[1:0], 1'b1};
      end
   end

   assign boot_load = (boot_wait_q == 3'h3) && strap_q;

   // register address decode, shared by write and read
   function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] a);
      return {a == SEL_B_OFFSET, a == SEL_A_OFFSET};
   endfunction : reg_hit

   logic [1:0] hit;
   assign hit = reg_hit(addr_i);

   // function select registers
   logic [15:0] sel_a_q;
   logic [15:0] sel_b_q;
   logic        wr_a;
   logic        wr_b;
   assign wr_a = wr_i && hit[0];
   assign wr_b = wr_i && hit[1];

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sel_a_q <= SEL_RESET;
      end else if (wr_a) begin
         sel_a_q <= wdata_i & SEL_A_WMASK;
      end else if (boot_load) begin
         sel_a_q <= SEL_A_BOOT16;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sel_b_q <= SEL_RESET;
      end else if (wr_b) begin
         sel_b_q <= wdata_i & SEL_B_WMASK;
      end else if (boot_load) begin
         sel_b_q <= SEL_B_BOOT16;
      end
   end

   // read data valid one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_o <= '0;
      end else if (rd_i && hit[0]) begin
         rdata_o <= sel_a_q;
      end else if (rd_i && hit[1]) begin
         rdata_o <= sel_b_q;
      end else begin
         rdata_o <= '0;
      end
   end

   // per-pin mode, index 0 is pin 19
   function automatic logic [1:0] pin_mode(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input int unsigned i);
      logic [31:0] all;
      all = {a, b};
      return all[PIN19_LSB + 2*i +: 2];
   endfunction : pin_mode

   logic [1:0] mode [PINS];
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_mode
         assign mode[gi] = pin_mode(sel_a_q, sel_b_q, gi);
      end
   endgenerate

   // alternate and trace drive per pin; inputs-only functions never drive
   pad_drive_s alt_drv   [PINS];
   pad_drive_s trace_drv [PINS];
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         alt_drv[i]   = '{o: 1'b0, oe: 1'b0};
         trace_drv[i] = '{o: 1'b0, oe: 1'b0};
      end
      alt_drv[8]   = '{o: dma_ack_ch1_i, oe: 1'b1};
      alt_drv[7]   = '{o: dma_ack_ch0_i, oe: 1'b1};
      trace_drv[4] = '{o: trace_sync_o_i, oe: trace_sync_oe_i};
      trace_drv[3] = '{o: trace_clock_o_i, oe: trace_clock_oe_i};
      trace_drv[0] = '{o: trace_data_bit3_o_i, oe: trace_data_bit3_oe_i};
   end

   // pad mux; code 11 on pins 24..27 is forbidden and drives nothing
   logic [PINS-1:0] pad_d;
   logic [PINS-1:0] pad_oe_d;
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         unique case (mode[i])
            MODE_PORT: begin
               pad_d[i]    = port_o_i[i];
               pad_oe_d[i] = port_oe_i[i];
            end
            MODE_BUS: begin
               pad_d[i]    = bus_o_i[i];
               pad_oe_d[i] = bus_oe_i[i];
            end
            MODE_ALT: begin
               pad_d[i]    = alt_drv[i].o;
               pad_oe_d[i] = alt_drv[i].oe;
            end
            MODE_TRACE: begin
               pad_d[i]    = trace_drv[i].o;
               pad_oe_d[i] = trace_drv[i].oe;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pad_o    <= '0;
         pad_oe_o <= '0;
      end else begin
         pad_o    <= pad_d;
         pad_oe_o <= pad_oe_d;
      end
   end

   // input routing: each peripheral sees the pin only when selected
   logic [PINS-1:0] port_in_d;
   logic [PINS-1:0] bus_in_d;
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         port_in_d[i] = (mode[i] == MODE_PORT) ? pad_q[i] : 1'b0;
         bus_in_d[i]  = (mode[i] == MODE_BUS)  ? pad_q[i] : 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         port_in_o <= '0;
         bus_in_o  <= '0;
      end else begin
         port_in_o <= port_in_d;
         bus_in_o  <= bus_in_d;
      end
   end

   // dma requests
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         dma_req_ch1_o <= 1'b0;
         dma_req_ch0_o <= 1'b0;
      end else begin
         dma_req_ch1_o <= (mode[6] == MODE_ALT) & pad_q[6];
         dma_req_ch0_o <= (mode[5] == MODE_ALT) & pad_q[5];
      end
   end

   // external interrupts 3..7 from pins 19..23
   logic [4:0] irq_d;
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         irq_d[i] = (mode[i] == MODE_ALT) & pad_q[i];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ext_interrupt_o <= '0;
      end else begin
         ext_interrupt_o <= irq_d;
      end
   end

   // trace inputs
   always_ff @(posedge clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         trace_sync_o      <= 1'b0;
         trace_clock_o     <= 1'b0;
         trace_mode_in_o   <= 1'b0;
         trace_reset_in_o  <= 1'b0;
         trace_data_bit3_o <= 1'b0;
      end else begin
         trace_sync_o      <= (mode[4] == MODE_TRACE) & pad_q[4];
         trace_clock_o     <= (mode[3] == MODE_TRACE) & pad_q[3];
         trace_mode_in_o   <= (mode[2] == MODE_TRACE) & pad_q[2];
         trace_reset_in_o  <= (mode[1] == MODE_TRACE) & pad_q[1];
         trace_data_bit3_o <= (mode[0] == MODE_TRACE) & pad_q[0];
      end
   end

endmodule : port_d_upper_pin_function_select

`default_nettype wire

// >>> pinsel_pkg.sv
package pinsel_pkg;

   // register bus
   localparam int unsigned ADDR_W         = 4;
   localparam int unsigned DATA_W         = 16;
   localparam logic [3:0]  SEL_A_OFFSET   = 4'h0;
   localparam logic [3:0]  SEL_B_OFFSET   = 4'h4;
   localparam logic [15:0] SEL_A_WMASK    = 16'h00FF;
   localparam logic [15:0] SEL_B_WMASK    = 16'hFFC0;
   localparam logic [15:0] SEL_RESET      = 16'h0000;
   localparam logic [15:0] SEL_A_BOOT16   = 16'h0055;
   localparam logic [15:0] SEL_B_BOOT16   = 16'h5540;

   // pin indices within the upper group (pin 19 is index 0)
   localparam int unsigned NPINS          = 9;
   localparam int unsigned PIN19_LSB      = 6;

   // mode codes
   localparam logic [1:0]  MODE_PORT      = 2'h0;
   localparam logic [1:0]  MODE_BUS       = 2'h1;
   localparam logic [1:0]  MODE_ALT       = 2'h2;
   localparam logic [1:0]  MODE_TRACE     = 2'h3;

   // one pad drive: output, output enable
   typedef struct packed {
      logic o;
      logic oe;
   } pad_drive_s;

endpackage : pinsel_pkg

// >>> pin_select_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pin_select_monitor
   import pinsel_pkg::*;
#(
   parameter int unsigned PINS = NPINS
) (
   // clock, reset, register port
   input wire logic              clk_i, reset_n_i, wr_i, rd_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i, rdata_o,
   // pads and routed signals
   input wire logic [PINS-1:0]   pad_i, pad_o, pad_oe_o, port_o_i, port_oe_i,
   input wire logic [PINS-1:0]   port_in_o, bus_o_i, bus_oe_i, bus_in_o,
   input wire logic [4:0]        ext_interrupt_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_rd(logic [3:0] ad);
      rd_i && addr_i == ad;
   endsequence
   property p_rd_idle;
      !rd_i |=> rdata_o == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_rd_a;
      s_rd(SEL_A_OFFSET) |=> rdata_o[15:8] == 8'h00;
   endproperty
   a_rd_a: assert property (p_rd_a) else $error("reserved A bits set");
   property p_rd_b;
      s_rd(SEL_B_OFFSET) |=> rdata_o[5:0] == 6'h00;
   endproperty
   a_rd_b: assert property (p_rd_b) else $error("reserved B bits set");
   property p_rd_unmapped;
      rd_i && addr_i != SEL_A_OFFSET && addr_i != SEL_B_OFFSET |=> rdata_o == 16'h0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
   property p_wr_rd_a;
      logic [15:0] d;
      (wr_i && addr_i == SEL_A_OFFSET, d = wdata_i) ##1 s_rd(SEL_A_OFFSET)
         |=> rdata_o == (d & SEL_A_WMASK);
   endproperty
   a_wr_rd_a: assert property (p_wr_rd_a) else $error("A readback");
   property p_in_pad;
      ((port_in_o | bus_in_o | {4'h0, ext_interrupt_o}) & ~$past(pad_i, 3)) == 9'h000;
   endproperty
   a_in_pad: assert property (p_in_pad) else $error("input without pad");
   property p_in_excl;
      (port_in_o & bus_in_o) == 9'h000;
   endproperty
   a_in_excl: assert property (p_in_excl) else $error("input to two owners");
   property p_oe_plain;
      (pad_oe_o & 9'h066 & ~($past(port_oe_i) | $past(bus_oe_i))) == 9'h000;
   endproperty
   a_oe_plain: assert property (p_oe_plain) else $error("input pin driven");
   property p_o_plain;
      (pad_o & pad_oe_o & 9'h066 & ~($past(port_o_i) | $past(bus_o_i))) == 9'h000;
   endproperty
   a_o_plain: assert property (p_o_plain) else $error("pad level wrong");
endmodule : pin_select_monitor
`default_nettype wire

// >>> port_d_upper_pin_function_select_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %0t got %h want %h", $time, g, e); end end
module port_d_upper_pin_function_select_test;
   import pinsel_pkg::*;
   localparam int unsigned PINS = NPINS;
   logic clk_i = 1'h0, reset_n_i = 1'h0, boot_ext16_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000, rdata_o, sel_a, sel_b;
   logic [8:0] pad_i = 9'h000, port_o_i = 9'h000, port_oe_i = 9'h000;
   logic [8:0] bus_o_i = 9'h000, bus_oe_i = 9'h000;
   logic [8:0] pad_o, pad_oe_o, port_in_o, bus_in_o, eo, ed, e0, e1, e2, e3;
   logic dma_ack_ch0_i = 1'h0, dma_ack_ch1_i = 1'h0, trace_sync_o_i = 1'h0;
   logic trace_sync_oe_i = 1'h0, trace_clock_o_i = 1'h0, trace_clock_oe_i = 1'h0;
   logic trace_data_bit3_o_i = 1'h0, trace_data_bit3_oe_i = 1'h0;
   logic dma_req_ch0_o, dma_req_ch1_o, trace_sync_o, trace_clock_o;
   logic trace_mode_in_o, trace_reset_in_o, trace_data_bit3_o;
   logic [4:0] ext_interrupt_o;
   logic [63:0] r;
   logic [1:0] m;
   int bad_count = 0, n_tests = 0, seed = 74;
   wire [6:0] alt_in = {dma_req_ch1_o, dma_req_ch0_o, ext_interrupt_o};
   wire [4:0] trc_in = {trace_sync_o, trace_clock_o, trace_mode_in_o, trace_reset_in_o,
                        trace_data_bit3_o};
   always #50 clk_i = ~clk_i;
   port_d_upper_pin_function_select #(.PINS(PINS)) port_d_upper_pin_function_select_inst (
      .clk_i, .reset_n_i, .boot_ext16_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .pad_i, .pad_o, .pad_oe_o, .port_o_i, .port_oe_i, .port_in_o, .bus_o_i, .bus_oe_i,
      .bus_in_o, .dma_ack_ch0_i, .dma_ack_ch1_i, .dma_req_ch0_o, .dma_req_ch1_o,
      .ext_interrupt_o, .trace_sync_o_i, .trace_sync_oe_i, .trace_clock_o_i, .trace_clock_oe_i,
      .trace_data_bit3_o_i, .trace_data_bit3_oe_i, .trace_sync_o, .trace_clock_o,
      .trace_mode_in_o, .trace_reset_in_o, .trace_data_bit3_o);
   task automatic do_reset(input logic boot);
      @(posedge clk_i);
      boot_ext16_i <= boot;
      reset_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask : do_reset
   // optional write, then read back the same address
   task automatic acc(input logic [3:0] ad, input logic [15:0] d, input bit w,
                      input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= ad;
      wdata_i <= d;
      wr_i <= w;
      rd_i <= !w;
      if (w) begin
         @(posedge clk_i);
         wr_i <= 1'b0;
         rd_i <= 1'b1;
      end
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 `CHK(rdata_o, exp)
   endtask : acc
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      do_reset(1'h0);
      acc(SEL_A_OFFSET, 16'h0000, 1'b0, SEL_RESET);
      acc(SEL_B_OFFSET, 16'h0000, 1'b0, SEL_RESET);
      acc(4'hC, 16'hFFFF, 1'b1, 16'h0000);
      $display("test registers done");
      // trace codes included: flash variant assumed
      for (int i = 0; i < 24; i++) begin
         r = {$random(seed), $random(seed)};
         m = i[1:0];
         sel_a = (i < 4) ? {8'h00, {4{m}}} : r[15:0];
         sel_b = (i < 4) ? {{5{m}}, 6'h00} : r[31:16];
         acc(SEL_A_OFFSET, sel_a, 1'b1, sel_a & SEL_A_WMASK);
         acc(SEL_B_OFFSET, sel_b, 1'b1, sel_b & SEL_B_WMASK);
         r = {$random(seed), $random(seed)};
         @(posedge clk_i);
         {pad_i, port_o_i, port_oe_i, bus_o_i, bus_oe_i, dma_ack_ch0_i, dma_ack_ch1_i,
          trace_sync_o_i, trace_sync_oe_i, trace_clock_o_i, trace_clock_oe_i,
          trace_data_bit3_o_i, trace_data_bit3_oe_i} <= r[52:0];
         repeat (4) @(posedge clk_i);
         #1;
         for (int k = 0; k < 9; k++) begin
            m = (k > 4) ? sel_a[2*k-10 +: 2] : sel_b[2*k+6 +: 2];
            eo[k] = (m == MODE_PORT) ? port_oe_i[k] : (m == MODE_BUS) & bus_oe_i[k];
            ed[k] = (m == MODE_PORT) ? port_o_i[k] : bus_o_i[k];
            e0[k] = (m == MODE_PORT) & pad_i[k];
            e1[k] = (m == MODE_BUS) & pad_i[k];
            e2[k] = (m == MODE_ALT) & pad_i[k];
            e3[k] = (m == MODE_TRACE) & pad_i[k];
         end
         if (sel_a[7:6] == MODE_ALT) {eo[8], ed[8]} = {1'b1, dma_ack_ch1_i};
         if (sel_a[5:4] == MODE_ALT) {eo[7], ed[7]} = {1'b1, dma_ack_ch0_i};
         if (sel_b[15:14] == MODE_TRACE) {eo[4], ed[4]} = {trace_sync_oe_i, trace_sync_o_i};
         if (sel_b[13:12] == MODE_TRACE) {eo[3], ed[3]} = {trace_clock_oe_i, trace_clock_o_i};
         if (sel_b[7:6] == MODE_TRACE) {eo[0], ed[0]} = {trace_data_bit3_oe_i, trace_data_bit3_o_i};
         `CHK(pad_oe_o, eo)
         `CHK(pad_o & eo, ed & eo)
         `CHK(port_in_o, e0)
         `CHK(bus_in_o, e1)
         `CHK(alt_in, e2[6:0])
         `CHK(trc_in, e3[4:0])
      end
      $display("test pin routing done");
      do_reset(1'h1);
      acc(SEL_A_OFFSET, 16'h0000, 1'b0, SEL_A_BOOT16);
      acc(SEL_B_OFFSET, 16'h0000, 1'b0, SEL_B_BOOT16);
      $display("test boot strap done");
      tally_and_finish();
   end
endmodule : port_d_upper_pin_function_select_test
bind port_d_upper_pin_function_select pin_select_monitor #(.PINS(PINS)) pin_select_monitor_inst (
   .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pad_i, .pad_o, .pad_oe_o,
   .port_o_i, .port_oe_i, .port_in_o, .bus_o_i, .bus_oe_i, .bus_in_o, .ext_interrupt_o);
`default_nettype wire
